// ==== design/scpf_defines.vh ====
`ifndef SCPF_DEFINES_VH
`define SCPF_DEFINES_VH

// Upper five bits of the two-wire chip address; the straps fill the low two
`define SCPF_CHIP_ADDR_HI 5'h0e
// Number of slave-select low pulses that switch the port to four-wire mode
`define SCPF_SS_TOGGLES 2'h3
// Cycles after reset release before the address straps are caught
`define SCPF_STRAP_DELAY 2'h3

// Subaddress map
`define SCPF_CTRL_BASE 16'hf000
`define SCPF_PLL_FIRST 16'hf000
`define SCPF_PLL_LAST 16'hf004

// Index of the last byte of a word: control registers two bytes, memory four
`define SCPF_CTRL_LAST_BYTE 2'h1
`define SCPF_RAM_LAST_BYTE 2'h3

// Byte positions in a transfer
`define SCPF_BYTE_CHIP 2'h0
`define SCPF_BYTE_SUB_HI 2'h1
`define SCPF_BYTE_SUB_LO 2'h2
`define SCPF_BYTE_DATA 2'h3

// Power-on value of every control register
`define SCPF_CTRL_DEFAULT 32'h00000000

// Storage shape: one bank of 256 memory words and one of 256 control words
`define SCPF_IDX_W 9
`define SCPF_DEPTH 512
`define SCPF_CTRL_SLOTS 256

`endif

// ==== design/scpf_buf2.v ====
`timescale 1ns/1ps
`default_nettype none

module scpf_buf2 #(
    parameter W = 48
) (
    // System
    input wire clk,
    input wire srst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output reg [W-1:0] out_data
);

reg [W-1:0] second;
reg [1:0] count;
wire push = in_valid & in_ready;
wire pop = out_valid & out_ready;

assign in_ready = (count != 2'h2);
assign out_valid = (count != 2'h0);

always @(posedge clk) begin
    if (srst) begin
        out_data <= {W{1'b0}};
        second <= {W{1'b0}};
        count <= 2'h0;
    end else begin
        case ({push, pop})
            2'b10: begin
                if (count == 2'h0)
                    out_data <= in_data;
                else
                    second <= in_data;
                count <= count + 2'h1;
            end
            2'b01: begin
                out_data <= second;
                count <= count - 2'h1;
            end
            2'b11: begin
                if (count == 2'h1) begin
                    out_data <= in_data;
                end else begin
                    out_data <= second;
                    second <= in_data;
                end
            end
            default: begin
                count <= count;
            end
        endcase
    end
end

endmodule // scpf_buf2

`default_nettype wire

// ==== design/scpf_mem.v ====
`timescale 1ns/1ps
`default_nettype none
`include "scpf_defines.vh"

module scpf_mem (
    // System
    input wire clk,
    input wire srst,
    // Write port
    input wire wr_en,
    input wire [`SCPF_IDX_W-1:0] wr_idx,
    input wire [31:0] wr_data,
    // Read port
    input wire rd_en,
    input wire [`SCPF_IDX_W-1:0] rd_idx,
    output reg [31:0] rd_data
);

reg [31:0] store [0:`SCPF_DEPTH-1];
reg [`SCPF_CTRL_SLOTS-1:0] ctrl_written;

// Array has no reset: memory words hold garbage until the program clears them
always @(posedge clk) begin
    if (wr_en)
        store[wr_idx] <= wr_data;
end

// Control words read their default until written after reset
always @(posedge clk) begin
    if (srst) begin
        ctrl_written <= {`SCPF_CTRL_SLOTS{1'b0}};
        rd_data <= 32'h00000000;
    end else begin
        if (wr_en && wr_idx[8])
            ctrl_written[wr_idx[7:0]] <= 1'b1;
        if (rd_en) begin
            if (rd_idx[8] && !ctrl_written[rd_idx[7:0]])
                rd_data <= `SCPF_CTRL_DEFAULT;
            else
                rd_data <= store[rd_idx];
        end
    end
end

endmodule // scpf_mem

`default_nettype wire

// ==== design/scpf_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "scpf_defines.vh"

// Notes on behaviour
// - Port starts two-wire; three slave-select low pulses switch it to four-wire.
// - Before PLL lock only subaddresses 0xF000 to 0xF004 are accessible.
// - Every location is readable and writable, singly or in bursts.
// - First byte holds seven-bit chip address then the read/write bit.
// - Second and third bytes form the sixteen-bit subaddress.
// - Data starts at the fourth byte; word length depends on location.
// - Control registers use two-byte words, memory uses four-byte words.
// - Subaddress advances after each word until stop or select goes high.
// - Burst write words follow directly and land at successive addresses.
// - Word length is decoded from the subaddress itself during bursts.
// - Subaddress steps by one per word, even over empty locations.
// - Select pin is address bit 0 in two-wire, active-low select in four-wire.
// - Serial-in pin is address bit 1 in two-wire, host data in four-wire.
// - Data pin open-drain two-wire, push-pull out four-wire; clock always input.
// - Reset disables everything; control registers return to power-on defaults.
// - Reset leaves memory contents undefined.
// - Two-wire address is fixed upper five bits plus the two strap pins.
// - Invalid subaddress is not acknowledged and the port goes idle.
// - Out-of-sequence stop returns the two-wire logic to idle; a start restarts it at the chip byte.
module scpf_top (
    // System
    input wire CLK_SYS,
    input wire SRST,
    // Control port pins
    input wire CONTROL_PORT_CLOCK_PIN,
    input wire SELECT_OR_ADDR_LSB_PIN,
    input wire SERIAL_IN_OR_ADDR_MSB_PIN,
    input wire DATA_PIN_I,
    output reg DATA_PIN_O,
    output reg DATA_PIN_OE_N,
    // Clock status and port mode
    input wire PLL_LOCKED,
    output wire FOUR_WIRE_MODE
);

localparam ST_IDLE = 5'h01;
localparam ST_RECV = 5'h02;
localparam ST_ACK = 5'h04;
localparam ST_SEND = 5'h08;
localparam ST_MACK = 5'h10;

// Pin synchronisers; logic reads the second stage, and edge detection also reads its one-cycle delayed copy
reg [1:0] scl_q;
reg [1:0] ss_q;
reg [1:0] mosi_q;
reg [1:0] sda_q;
reg [1:0] lock_q;
reg scl_d;
reg ss_d;
reg sda_d;

always @(posedge CLK_SYS) begin
    if (SRST) begin
        scl_q <= 2'h3;
        ss_q <= 2'h3;
        mosi_q <= 2'h0;
        sda_q <= 2'h3;
        lock_q <= 2'h0;
        scl_d <= 1'b1;
        ss_d <= 1'b1;
        sda_d <= 1'b1;
    end else begin
        scl_q <= {scl_q[0], CONTROL_PORT_CLOCK_PIN};
        ss_q <= {ss_q[0], SELECT_OR_ADDR_LSB_PIN};
        mosi_q <= {mosi_q[0], SERIAL_IN_OR_ADDR_MSB_PIN};
        sda_q <= {sda_q[0], DATA_PIN_I};
        lock_q <= {lock_q[0], PLL_LOCKED};
        scl_d <= scl_q[1];
        ss_d <= ss_q[1];
        sda_d <= sda_q[1];
    end
end

wire scl = scl_q[1];
wire ss = ss_q[1];
wire mosi = mosi_q[1];
wire sda = sda_q[1];
wire locked = lock_q[1];

reg spi_mode;
wire scl_rise = scl & ~scl_d;
wire scl_fall = ~scl & scl_d;
wire ss_fall = ~ss & ss_d;
wire i2c_start = ~spi_mode & scl & scl_d & ~sda & sda_d;
wire i2c_stop = ~spi_mode & scl & scl_d & sda & ~sda_d;

// Mode switch and strap capture
reg [1:0] ss_count;
reg [1:0] strap_wait;
reg strap_done;
reg [1:0] strap;

assign FOUR_WIRE_MODE = spi_mode;

always @(posedge CLK_SYS) begin
    if (SRST) begin
        spi_mode <= 1'b0;
        ss_count <= 2'h0;
        strap_wait <= 2'h0;
        strap_done <= 1'b0;
        strap <= 2'h0;
    end else begin
        // Wait for the synchronisers to fill before trusting the straps
        if (!strap_done) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == `SCPF_STRAP_DELAY) begin
                strap <= {mosi, ss};
                strap_done <= 1'b1;
            end
        end
        // Pulses shorter than one system clock may be missed
        if (strap_done && !spi_mode && ss_fall) begin
            ss_count <= ss_count + 2'h1;
            if (ss_count == `SCPF_SS_TOGGLES - 2'h1)
                spi_mode <= 1'b1;
        end
    end
end

function is_ctrl;
    input [15:0] a;
    begin
        is_ctrl = (a >= `SCPF_CTRL_BASE);
    end
endfunction

function allowed;
    input [15:0] a;
    input lk;
    begin
        allowed = lk || ((a >= `SCPF_PLL_FIRST) && (a <= `SCPF_PLL_LAST));
    end
endfunction

function [1:0] last_byte;
    input [15:0] a;
    begin
        last_byte = is_ctrl(a) ? `SCPF_CTRL_LAST_BYTE : `SCPF_RAM_LAST_BYTE;
    end
endfunction

// Transfer engine
reg [4:0] state;
reg [2:0] bitcnt;
reg [7:0] shreg;
reg [1:0] byte_idx;
reg rw;
reg [15:0] sub_addr;
reg [23:0] word_acc;
reg [1:0] wbyte;
reg ack_ok;
reg ack_phase;
reg [7:0] tx;
reg rd_fetch;
reg rd_ok;
reg wr_pend;
reg [47:0] wr_word;
reg [7:0] cur_byte;

wire rx_bit = spi_mode ? mosi : sda;
wire [7:0] rx_byte = {shreg[6:0], rx_bit};
wire buf_in_ready;
wire buf_out_valid;
wire [47:0] buf_out_data;
wire [31:0] mem_rdata;
wire [31:0] rd_word = rd_ok ? mem_rdata : 32'h00000000;
wire buf_out_ready = ~rd_fetch;

// Most significant byte of a word goes out first
always @* begin
    case ({is_ctrl(sub_addr), wbyte})
        3'h0: cur_byte = rd_word[31:24];
        3'h1: cur_byte = rd_word[23:16];
        3'h2: cur_byte = rd_word[15:8];
        3'h3: cur_byte = rd_word[7:0];
        3'h4: cur_byte = rd_word[15:8];
        3'h5: cur_byte = rd_word[7:0];
        default: cur_byte = 8'h00;
    endcase
end

always @(posedge CLK_SYS) begin
    if (SRST) begin
        state <= ST_IDLE;
        bitcnt <= 3'h0;
        shreg <= 8'h00;
        byte_idx <= `SCPF_BYTE_CHIP;
        rw <= 1'b0;
        sub_addr <= 16'h0000;
        word_acc <= 24'h000000;
        wbyte <= 2'h0;
        ack_ok <= 1'b0;
        ack_phase <= 1'b0;
        tx <= 8'h00;
        rd_fetch <= 1'b0;
        rd_ok <= 1'b0;
        wr_pend <= 1'b0;
        wr_word <= 48'h000000000000;
    end else begin
        rd_fetch <= 1'b0;
        if (rd_fetch)
            rd_ok <= allowed(sub_addr, locked);
        if (wr_pend && buf_in_ready)
            wr_pend <= 1'b0;
        if (spi_mode && ss) begin
            state <= ST_IDLE;
            ack_phase <= 1'b0;
        end else if (spi_mode && ss_fall) begin
            state <= ST_RECV;
            bitcnt <= 3'h0;
            byte_idx <= `SCPF_BYTE_CHIP;
        end else if (i2c_stop) begin
            state <= ST_IDLE;
            ack_phase <= 1'b0;
        end else if (i2c_start) begin
            // Repeated start keeps the subaddress for a following read
            state <= ST_RECV;
            bitcnt <= 3'h0;
            byte_idx <= `SCPF_BYTE_CHIP;
            ack_phase <= 1'b0;
        end else begin
            case (state)
                ST_RECV: begin
                    if (scl_rise) begin
                        shreg <= rx_byte;
                        bitcnt <= bitcnt + 3'h1;
                        if (bitcnt == 3'h7) begin
                            state <= spi_mode ? ST_RECV : ST_ACK;
                            ack_phase <= 1'b0;
                            ack_ok <= 1'b1;
                            case (byte_idx)
                                `SCPF_BYTE_CHIP: begin
                                    rw <= rx_byte[0];
                                    byte_idx <= `SCPF_BYTE_SUB_HI;
                                    if (!spi_mode &&
                                        rx_byte[7:1] != {`SCPF_CHIP_ADDR_HI, strap[1], strap[0]})
                                        ack_ok <= 1'b0;
                                    if (!spi_mode && rx_byte[0]) begin
                                        byte_idx <= `SCPF_BYTE_DATA;
                                        wbyte <= 2'h0;
                                        rd_fetch <= 1'b1;
                                    end
                                end
                                `SCPF_BYTE_SUB_HI: begin
                                    sub_addr[15:8] <= rx_byte;
                                    byte_idx <= `SCPF_BYTE_SUB_LO;
                                end
                                `SCPF_BYTE_SUB_LO: begin
                                    sub_addr[7:0] <= rx_byte;
                                    byte_idx <= `SCPF_BYTE_DATA;
                                    wbyte <= 2'h0;
                                    if (!spi_mode && !allowed({sub_addr[15:8], rx_byte}, locked))
                                        ack_ok <= 1'b0;
                                    if (spi_mode && rw) begin
                                        state <= ST_SEND;
                                        rd_fetch <= 1'b1;
                                    end
                                end
                                default: begin
                                    word_acc <= {word_acc[15:0], rx_byte};
                                    if (wbyte == last_byte(sub_addr)) begin
                                        wbyte <= 2'h0;
                                        sub_addr <= sub_addr + 16'h0001;
                                        // A full buffer refuses the word rather than losing it
                                        if (wr_pend && !buf_in_ready)
                                            ack_ok <= 1'b0;
                                        else if (allowed(sub_addr, locked)) begin
                                            wr_pend <= 1'b1;
                                            if (is_ctrl(sub_addr))
                                                wr_word <= {sub_addr, 16'h0000, word_acc[7:0], rx_byte};
                                            else
                                                wr_word <= {sub_addr, word_acc, rx_byte};
                                        end
                                    end else begin
                                        wbyte <= wbyte + 2'h1;
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!ack_phase) begin
                            if (ack_ok)
                                ack_phase <= 1'b1;
                            else
                                state <= ST_IDLE;
                        end else begin
                            ack_phase <= 1'b0;
                            if (rw && byte_idx == `SCPF_BYTE_DATA) begin
                                state <= ST_SEND;
                                tx <= cur_byte;
                                bitcnt <= 3'h0;
                            end else begin
                                state <= ST_RECV;
                            end
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_rise) begin
                        bitcnt <= bitcnt + 3'h1;
                        if (bitcnt == 3'h7) begin
                            if (wbyte == last_byte(sub_addr)) begin
                                wbyte <= 2'h0;
                                sub_addr <= sub_addr + 16'h0001;
                                rd_fetch <= 1'b1;
                            end else begin
                                wbyte <= wbyte + 2'h1;
                            end
                        end
                    end
                    if (scl_fall) begin
                        if (bitcnt != 3'h0)
                            tx <= {tx[6:0], 1'b0};
                        else if (spi_mode)
                            tx <= cur_byte;
                        else
                            state <= ST_MACK;
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        if (sda)
                            state <= ST_IDLE;
                        else
                            ack_phase <= 1'b1;
                    end
                    if (scl_fall && ack_phase) begin
                        ack_phase <= 1'b0;
                        state <= ST_SEND;
                        tx <= cur_byte;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
end

// Data pin drive
always @(posedge CLK_SYS) begin
    if (SRST) begin
        DATA_PIN_O <= 1'b0;
        DATA_PIN_OE_N <= 1'b1;
    end else if (spi_mode) begin
        DATA_PIN_O <= tx[7];
        DATA_PIN_OE_N <= ss;
    end else begin
        // Open drain: only ever pull low
        DATA_PIN_O <= 1'b0;
        DATA_PIN_OE_N <= ~((state == ST_ACK && ack_phase) || (state == ST_SEND && !tx[7]));
    end
end

// Words wait here while the store is busy with a read
scpf_buf2 #(
    .W(48)
) u_buf (
    .clk(CLK_SYS),
    .srst(SRST),
    .in_valid(wr_pend),
    .in_ready(buf_in_ready),
    .in_data(wr_word),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
);

scpf_mem u_mem (
    .clk(CLK_SYS),
    .srst(SRST),
    .wr_en(buf_out_valid & buf_out_ready),
    .wr_idx({is_ctrl(buf_out_data[47:32]), buf_out_data[39:32]}),
    .wr_data(buf_out_data[31:0]),
    .rd_en(rd_fetch),
    .rd_idx({is_ctrl(sub_addr), sub_addr[7:0]}),
    .rd_data(mem_rdata)
);

endmodule // scpf_top

`default_nettype wire

// ==== verification/scpf_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module scpf_asserts (
    // System
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Control port pins
    input wire logic CONTROL_PORT_CLOCK_PIN,
    input wire logic SELECT_OR_ADDR_LSB_PIN,
    input wire logic DATA_PIN_O,
    input wire logic DATA_PIN_OE_N,
    input wire logic FOUR_WIRE_MODE
);
    logic sel_q;
    logic [1:0] falls;
    // Saturates so that select traffic in four-wire mode cannot wrap it
    always @(posedge CLK_SYS) begin
        sel_q <= SELECT_OR_ADDR_LSB_PIN;
        if (SRST) begin
            falls <= 2'h0;
        end else if (sel_q && !SELECT_OR_ADDR_LSB_PIN && falls != 2'h3) begin
            falls <= falls + 2'h1;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    sequence s_sel_lo;
        FOUR_WIRE_MODE && !SELECT_OR_ADDR_LSB_PIN;
    endsequence
    sequence s_sel_hi;
        FOUR_WIRE_MODE && SELECT_OR_ADDR_LSB_PIN;
    endsequence
    sequence s_ack_on;
        !FOUR_WIRE_MODE && $fell(DATA_PIN_OE_N);
    endsequence
    AST_RST_IDLE: assert property ($fell(SRST) |-> DATA_PIN_OE_N && !FOUR_WIRE_MODE)
        else $error("port not idle after reset");
    AST_MODE_STICKY: assert property ($fell(FOUR_WIRE_MODE) |-> $past(SRST))
        else $error("four-wire mode left without reset");
    AST_MODE_ENTRY: assert property ($fell(SELECT_OR_ADDR_LSB_PIN) && falls == 2'h2
        |-> ##[1:8] FOUR_WIRE_MODE) else $error("third select pulse ignored");
    AST_MODE_COUNT: assert property ($rose(FOUR_WIRE_MODE) |-> falls == 2'h3)
        else $error("four-wire mode entered early");
    AST_OD_LOW: assert property (!FOUR_WIRE_MODE |-> !DATA_PIN_O)
        else $error("data pin driven high in two-wire mode");
    // Sync delay is a few cycles, so the clock is looked at three cycles back
    AST_ACK_EDGE: assert property (!FOUR_WIRE_MODE && $changed(DATA_PIN_OE_N)
        |-> !$past(CONTROL_PORT_CLOCK_PIN, 3)) else $error("data moved while clock high");
    AST_ACK_HOLD: assert property (s_ack_on |=> !DATA_PIN_OE_N [*5])
        else $error("acknowledge released early");
    AST_MISO_EDGE: assert property (FOUR_WIRE_MODE && !DATA_PIN_OE_N && $changed(DATA_PIN_O)
        |-> !$past(CONTROL_PORT_CLOCK_PIN, 3)) else $error("output bit moved while clock high");
    AST_SPI_DRIVE: assert property (s_sel_lo [*6] |-> !DATA_PIN_OE_N)
        else $error("output not driven while selected");
    AST_SPI_RELEASE: assert property (s_sel_hi [*6] |-> DATA_PIN_OE_N)
        else $error("output driven while deselected");
endmodule // scpf_asserts
bind scpf_top scpf_asserts u_asserts (
    .CLK_SYS(CLK_SYS),
    .SRST(SRST),
    .CONTROL_PORT_CLOCK_PIN(CONTROL_PORT_CLOCK_PIN),
    .SELECT_OR_ADDR_LSB_PIN(SELECT_OR_ADDR_LSB_PIN),
    .DATA_PIN_O(DATA_PIN_O),
    .DATA_PIN_OE_N(DATA_PIN_OE_N),
    .FOUR_WIRE_MODE(FOUR_WIRE_MODE)
);
`default_nettype wire

// ==== verification/scpf_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module scpf_host (
    // Clock and resolved data wire
    input wire logic clk,
    input wire logic sda,
    // Pins driven by the host
    output logic scl,
    output logic sda_low,
    output logic sel,
    output logic mosi
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        sel = 1'b1;
        mosi = 1'b0;
    end
    task automatic hp(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Data only moves mid-way through the low phase
    task automatic bt(input logic b, output logic r);
        hp(2);
        sda_low = !b;
        hp(2);
        scl = 1'b1;
        hp(4);
        r = sda;
        scl = 1'b0;
    endtask
    task automatic st();
        sda_low = 1'b0;
        hp(4);
        scl = 1'b1;
        hp(4);
        sda_low = 1'b1;
        hp(4);
        scl = 1'b0;
    endtask
    task automatic sp();
        sda_low = 1'b1;
        hp(4);
        scl = 1'b1;
        hp(4);
        sda_low = 1'b0;
        hp(4);
    endtask
    task automatic wb(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bt(d[i], r);
        end
        bt(1'b1, r);
        ack = !r;
    endtask
    // Two-wire transfer: nw data bytes written, then nr bytes read after a repeated start
    task automatic xfer_2w(input logic [6:0] chip, input logic [15:0] sub,
            input logic [63:0] d, input int nw, input int nr, output int acks,
            output logic [63:0] q);
        logic [23:0] g;
        logic [7:0] b;
        logic a;
        g = {chip, 1'b0, sub};
        acks = 0;
        q = '0;
        st();
        for (int k = nw + 2; k >= 0; k--) begin
            wb(k >= nw ? g[8*(k-nw) +: 8] : d[8*k +: 8], a);
            acks += int'(a);
        end
        if (nr > 0) begin
            st();
            wb({chip, 1'b1}, a);
            acks += int'(a);
            for (int k = nr - 1; k >= 0; k--) begin
                for (int i = 7; i >= 0; i--) begin
                    bt(1'b1, b[i]);
                end
                bt(k == 0, a);
                q[8*k +: 8] = b;
            end
        end
        sp();
    endtask
    // Pulses stay low three system clocks, above the one-period minimum
    task automatic to_4w(input int n);
        scl = 1'b0;
        repeat (n) begin
            sel = 1'b0;
            hp(3);
            sel = 1'b1;
            hp(3);
        end
    endtask
    // Clock idles low; returned bits are taken late in the high phase
    task automatic xfer_4w(input logic rd, input logic [15:0] sub, input logic [63:0] d,
            input int nb, output logic [63:0] q);
        logic [23:0] g;
        g = {7'h39, rd, sub};
        q = '0;
        sel = 1'b0;
        hp(4);
        for (int k = nb + 2; k >= 0; k--) begin
            for (int i = 7; i >= 0; i--) begin
                mosi = k >= nb ? g[8*(k-nb)+i] : d[8*k+i];
                hp(4);
                scl = 1'b1;
                hp(4);
                // Header bits carry no read data; only data bytes are collected
                if (k < nb)
                    q[8*k+i] = sda;
                scl = 1'b0;
            end
        end
        hp(4);
        mosi = 1'b0;
        sel = 1'b1;
        hp(8);
    endtask
endmodule // scpf_host
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic lock = 1'b0;
    logic scl, sda_low, sel, mosi;
    wire dout, oe_n, fwm;
    // Pull-up on the data wire; the device drives only while enabled
    wire sda = sda_low ? 1'b0 : (oe_n ? 1'b1 : dout);
    int err_total = 0;
    int checked = 0;
    int a;
    logic [63:0] q;
    // Fixed upper bits, serial-in strap low, select strap high
    localparam logic [6:0] CHIP = 7'h39;
    always #25 clk = ~clk;
    scpf_top u_dut (
        .CLK_SYS(clk), .SRST(srst), .CONTROL_PORT_CLOCK_PIN(scl),
        .SELECT_OR_ADDR_LSB_PIN(sel), .SERIAL_IN_OR_ADDR_MSB_PIN(mosi), .DATA_PIN_I(sda),
        .DATA_PIN_O(dout), .DATA_PIN_OE_N(oe_n), .PLL_LOCKED(lock), .FOUR_WIRE_MODE(fwm)
    );
    scpf_host u_host (
        .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low), .sel(sel), .mosi(mosi)
    );
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task rst_dut;
        srst = 1'b1;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        repeat (12) @(negedge clk);
    endtask
    task t_gate;
        u_host.xfer_2w(7'h3a, 16'hf000, 64'h1234, 2, 0, a, q);
        chk(a, 0);
        u_host.xfer_2w(CHIP, 16'hf004, 64'h00a5, 2, 0, a, q);
        chk(a, 5);
        u_host.xfer_2w(CHIP, 16'hf005, 64'h1234, 2, 0, a, q);
        chk(a, 2);
        u_host.xfer_2w(CHIP, 16'hf004, 64'h0, 0, 2, a, q);
        chk(q, 64'h00a5);
        chk(a, 4);
    endtask
    task t_burst;
        lock = 1'b1;
        repeat (8) @(negedge clk);
        u_host.xfer_2w(CHIP, 16'hf400, 64'h0001, 2, 0, a, q);
        chk(a, 5);
        u_host.xfer_2w(CHIP, 16'hefff, 64'hdead_beef_5a5a, 6, 0, a, q);
        chk(a, 9);
        u_host.xfer_2w(CHIP, 16'hefff, 64'h0, 0, 8, a, q);
        chk(q, 64'hdead_beef_5a5a_0000);
        u_host.xfer_2w(CHIP, 16'hf000, 64'h0, 0, 2, a, q);
        chk(q, 64'h5a5a);
        u_host.xfer_2w(CHIP, 16'hf402, 64'h0001, 2, 0, a, q);
    endtask
    task t_spi;
        u_host.to_4w(2);
        repeat (10) @(negedge clk);
        chk(fwm, 1'b0);
        u_host.to_4w(1);
        repeat (10) @(negedge clk);
        chk(fwm, 1'b1);
        u_host.xfer_4w(1'b0, 16'h0020, 64'hcafe_f00d, 4, q);
        u_host.xfer_4w(1'b1, 16'h0020, 64'h0, 4, q);
        chk(q, 64'hcafe_f00d);
    endtask
    // Run takes well under half a millisecond; the limit leaves ample margin
    initial begin
        #3000000;
        err_total++;
        close_out;
    end
    initial begin
        rst_dut;
        chk({oe_n, dout, fwm}, 3'b100);
        t_gate;
        t_burst;
        t_spi;
        rst_dut;
        chk(fwm, 1'b0);
        u_host.xfer_2w(CHIP, 16'hf000, 64'h0, 0, 2, a, q);
        chk(q, 64'h0);
        close_out;
    end
endmodule // tb_top
`default_nettype wire
